// ===== design/cal1_regs.v
`timescale 1ns/1ns
`default_nettype none
`include "cal1_regs_defs.vh"
module cal1_regs (
  input  wire        core_clk,
  input  wire        rst_b,
  input  wire [5:0]  reg_addr,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [15:0] reg_wdata,
  input  wire        checksum_load,
  input  wire [15:0] checksum_value,
  output reg  [15:0] reg_rdata,
  output reg         reg_rvalid,
  output reg  [23:0] offset_corr,
  output reg  [23:0] gain_corr
);

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  function hit;
    input [5:0] addr;
    input [5:0] target;
    begin
      hit = (addr == target);
    end
  endfunction

  // one write strobe per writable word
  wire wr_off_hi = reg_wr & hit(reg_addr, `CAL1_ADDR_OFFSET_HIGH);
  wire wr_off_lo = reg_wr & hit(reg_addr, `CAL1_ADDR_OFFSET_LOW);
  wire wr_gain_hi = reg_wr & hit(reg_addr, `CAL1_ADDR_GAIN_HIGH);
  wire wr_gain_lo = reg_wr & hit(reg_addr, `CAL1_ADDR_GAIN_LOW);
  wire wr_top = reg_wr & hit(reg_addr, `CAL1_ADDR_TOP_RESERVED);
  // no strobe for 3Eh: a bus write cannot reach the checksum

  // ----------------------------------------
  // field helpers
  // ----------------------------------------
  // low field of a lower register; the reserved byte is dropped on write
  function [7:0] low_field;
    input [15:0] word;
    begin
      low_field = word[`CAL1_LOW_FIELD_MSB:`CAL1_LOW_FIELD_LSB];
    end
  endfunction

  // read view of a lower register; reserved byte always zero
  function [15:0] pad_low;
    input [7:0] field;
    begin
      pad_low = {field, `CAL1_RSVD_BYTE};
    end
  endfunction

  // 24-bit correction value: upper word first, then the low byte
  function [23:0] pack_corr;
    input [15:0] upper;
    input [7:0]  lower;
    begin
      pack_corr = {upper, lower};
    end
  endfunction

  // ----------------------------------------
  // storage
  // ----------------------------------------
  wire [15:0] offset_value_upper_bits;
  wire [15:0] gain_value_upper_bits;
  reg  [7:0]  offset_value_lower_bits;
  reg  [7:0]  gain_value_lower_bits;
  reg  [15:0] register_map_checksum;
  reg  [15:0] top_reserved_word;

  // upper words share one small storage module
  cal1_word_reg #(.RESET_VALUE(`CAL1_RST_OFFSET_HIGH)) u_off_hi (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .wr_en    (wr_off_hi),
    .wr_data  (reg_wdata),
    .value    (offset_value_upper_bits)
  );

  cal1_word_reg #(.RESET_VALUE(`CAL1_RST_GAIN_HIGH)) u_gain_hi (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .wr_en    (wr_gain_hi),
    .wr_data  (reg_wdata),
    .value    (gain_value_upper_bits)
  );

  // ----------------------------------------
  // lower bytes
  // ----------------------------------------
  // only bits 15:8 of a write are kept; the reserved byte is never stored
  reg  [7:0]  next_offset_lower;
  reg  [7:0]  next_gain_lower;

  // hold unless this word is written
  always @* begin
    next_offset_lower = offset_value_lower_bits;
    next_gain_lower   = gain_value_lower_bits;
    if (wr_off_lo) begin
      next_offset_lower = low_field(reg_wdata);
    end
    if (wr_gain_lo) begin
      next_gain_lower = low_field(reg_wdata);
    end
  end

  // async reset to a constant only
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      offset_value_lower_bits <= `CAL1_RST_LOW_BYTE;
      gain_value_lower_bits   <= `CAL1_RST_LOW_BYTE;
    end else begin
      offset_value_lower_bits <= next_offset_lower;
      gain_value_lower_bits   <= next_gain_lower;
    end
  end

  // ----------------------------------------
  // register map checksum
  // ----------------------------------------
  // loaded by the core side only; the sum itself is formed outside
  reg  [15:0] next_checksum;

  // hold unless the core loads a new sum
  always @* begin
    next_checksum = register_map_checksum;
    if (checksum_load) begin
      next_checksum = checksum_value;
    end
  end

  // zero out of reset
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      register_map_checksum <= `CAL1_RST_CHECKSUM;
    end else begin
      register_map_checksum <= next_checksum;
    end
  end

  // ----------------------------------------
  // reserved top word
  // ----------------------------------------
  // stored as written; the host keeps it at zero, so it reads zero
  // limitation: a nonzero host write would read back as written
  reg  [15:0] next_top_reserved;

  // hold unless the word is written
  always @* begin
    next_top_reserved = top_reserved_word;
    if (wr_top) begin
      next_top_reserved = reg_wdata;
    end
  end

  // zero out of reset
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      top_reserved_word <= `CAL1_RST_TOP_RESERVED;
    end else begin
      top_reserved_word <= next_top_reserved;
    end
  end

  // ----------------------------------------
  // read multiplexer
  // ----------------------------------------
  // unmapped addresses read zero; without a read the last data stands
  // a read and a write to one word in one cycle return the old word
  reg  [15:0] next_rdata;

  // reserved low bytes come from pad_low; the reserved top word at 3Fh comes from storage
  always @* begin
    next_rdata = reg_rdata;
    if (reg_rd) begin
      case (reg_addr)
        `CAL1_ADDR_OFFSET_HIGH:  next_rdata = offset_value_upper_bits;
        `CAL1_ADDR_OFFSET_LOW:   next_rdata = pad_low(offset_value_lower_bits);
        `CAL1_ADDR_GAIN_HIGH:    next_rdata = gain_value_upper_bits;
        `CAL1_ADDR_GAIN_LOW:     next_rdata = pad_low(gain_value_lower_bits);
        `CAL1_ADDR_CHECKSUM:     next_rdata = register_map_checksum;
        `CAL1_ADDR_TOP_RESERVED: next_rdata = top_reserved_word;
        default:                 next_rdata = 16'h0000;
      endcase
    end
  end

  // ----------------------------------------
  // correction values
  // ----------------------------------------
  // registered so the outputs come from flops; one edge behind storage
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      offset_corr <= {`CAL1_RST_OFFSET_HIGH, `CAL1_RST_LOW_BYTE};
      gain_corr   <= {`CAL1_RST_GAIN_HIGH, `CAL1_RST_LOW_BYTE};
    end else begin
      offset_corr <= pack_corr(offset_value_upper_bits, offset_value_lower_bits);
      gain_corr   <= pack_corr(gain_value_upper_bits, gain_value_lower_bits);
    end
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  // data and valid both one edge after the read strobe
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata  <= 16'h0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rdata  <= next_rdata;
      reg_rvalid <= reg_rd;
    end
  end

endmodule
`default_nettype wire

// ===== shared/cal1_regs_defs.vh
// Notes on behaviour
// - offset upper word at 0Fh, rw, zero reset
// - offset low byte at 10h[15:8], rest reads zero
// - gain upper word at 11h, rw, resets 8000h
// - gain low byte at 12h[15:8], rest zero
// - checksum at 3Eh, read only, zero reset
// - reserved word at 3Fh, zero after reset
`ifndef CAL1_REGS_DEFS_VH
`define CAL1_REGS_DEFS_VH

// ----------------------------------------
// register addresses
// ----------------------------------------
`define CAL1_ADDR_W             6
`define CAL1_ADDR_OFFSET_HIGH   6'h0F
`define CAL1_ADDR_OFFSET_LOW    6'h10
`define CAL1_ADDR_GAIN_HIGH     6'h11
`define CAL1_ADDR_GAIN_LOW      6'h12
`define CAL1_ADDR_CHECKSUM      6'h3E
`define CAL1_ADDR_TOP_RESERVED  6'h3F

// ----------------------------------------
// reset values and fields
// ----------------------------------------
`define CAL1_RST_OFFSET_HIGH    16'h0000
`define CAL1_RST_LOW_BYTE       8'h00
`define CAL1_RST_GAIN_HIGH      16'h8000
`define CAL1_RST_CHECKSUM       16'h0000
`define CAL1_RST_TOP_RESERVED   16'h0000
`define CAL1_LOW_FIELD_MSB      15
`define CAL1_LOW_FIELD_LSB      8
`define CAL1_RSVD_BYTE          8'h00

`endif

// ===== design/cal1_word_reg.v
`timescale 1ns/1ns
`default_nettype none
module cal1_word_reg #(
  parameter [15:0] RESET_VALUE = 16'h0000
) (
  input  wire        core_clk,
  input  wire        rst_b,
  input  wire        wr_en,
  input  wire [15:0] wr_data,
  output reg  [15:0] value
);

  // ----------------------------------------
  // storage word
  // ----------------------------------------
  // async reset to a constant only
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      value <= RESET_VALUE;
    end else if (wr_en) begin
      value <= wr_data;
    end
  end

endmodule
`default_nettype wire

// ===== verif/cal1_host.sv
`timescale 1ns/1ns
`default_nettype none
// ------
// host side: strobes launched just after an edge
// ------
module cal1_host (
  input  wire logic        core_clk,
  input  wire logic [15:0] reg_rdata,
  input  wire logic        reg_rvalid,
  output var  logic [5:0]  reg_addr,
  output var  logic        reg_wr,
  output var  logic        reg_rd,
  output var  logic [15:0] reg_wdata
);
  initial begin
    {reg_addr, reg_wr, reg_rd, reg_wdata} = 24'h000000;
  end
  // top word only ever written with zero
  task wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= (a == 6'h3F) ? 16'h0000 : d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d; // stale data never left standing
  endtask
  // data taken at the edge that samples the valid pulse; unknown if none
  task rd(input logic [5:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    d = reg_rvalid ? reg_rdata : 16'hXXXX;
  endtask
endmodule
`default_nettype wire

// ===== verif/cal1_regs_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module cal1_regs_asserts (
  input wire logic        core_clk,
  input wire logic        rst_b,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic        checksum_load,
  input wire logic        reg_rvalid,
  input wire logic [5:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] checksum_value,
  input wire logic [15:0] reg_rdata,
  input wire logic [23:0] offset_corr,
  input wire logic [23:0] gain_corr
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // shadow of the loaded checksum, zero out of reset
  logic [15:0] crc_q;
  always @(posedge core_clk or negedge rst_b)
    if (!rst_b) crc_q <= 16'h0000;
    else if (checksum_load) crc_q <= checksum_value;
  property p_oh; $past(reg_wr&&reg_addr==6'h0F,2) |-> offset_corr[23:8]==$past(reg_wdata,2); endproperty
  a_oh: assert property (p_oh) else $error("offset high");
  property p_ol; $past(reg_wr&&reg_addr==6'h10,2) |-> offset_corr[7:0]==$past(reg_wdata[15:8],2); endproperty
  a_ol: assert property (p_ol) else $error("offset low");
  property p_gh; $past(reg_wr&&reg_addr==6'h11,2) |-> gain_corr[23:8]==$past(reg_wdata,2); endproperty
  a_gh: assert property (p_gh) else $error("gain high");
  property p_gl; $past(reg_wr&&reg_addr==6'h12,2) |-> gain_corr[7:0]==$past(reg_wdata[15:8],2); endproperty
  a_gl: assert property (p_gl) else $error("gain low");
  property p_rz; reg_rvalid && $past(reg_addr[5:2]==4'h4 && !reg_addr[0]) |-> reg_rdata[7:0]==8'h00; endproperty
  a_rz: assert property (p_rz) else $error("low byte");
  property p_crc; reg_rd && reg_addr==6'h3E |=> reg_rdata==$past(crc_q); endproperty
  a_crc: assert property (p_crc) else $error("checksum");
  property p_rv; reg_rvalid == $past(reg_rd); endproperty
  a_rv: assert property (p_rv) else $error("read valid");
  property p_rsv; reg_rvalid && $past(reg_addr==6'h3F) |-> reg_rdata==16'h0000; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved word");
endmodule
bind cal1_regs cal1_regs_asserts u_chk (
  .core_clk       (core_clk),
  .rst_b          (rst_b),
  .reg_wr         (reg_wr),
  .reg_rd         (reg_rd),
  .checksum_load  (checksum_load),
  .reg_rvalid     (reg_rvalid),
  .reg_addr       (reg_addr),
  .reg_wdata      (reg_wdata),
  .checksum_value (checksum_value),
  .reg_rdata      (reg_rdata),
  .offset_corr    (offset_corr),
  .gain_corr      (gain_corr)
);
`default_nettype wire

// ===== verif/cal1_regs_tb.sv
`timescale 1ns/1ns
`default_nettype none
module cal1_regs_tb;
  logic        core_clk, rst_b, reg_wr, reg_rd, reg_rvalid, checksum_load;
  logic [5:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, checksum_value, rv;
  logic [23:0] offset_corr, gain_corr;
  int          error_cnt, cmp_count, cyc;
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  cal1_regs u_dut (
    .core_clk       (core_clk),
    .rst_b          (rst_b),
    .reg_addr       (reg_addr),
    .reg_wr         (reg_wr),
    .reg_rd         (reg_rd),
    .reg_wdata      (reg_wdata),
    .checksum_load  (checksum_load),
    .checksum_value (checksum_value),
    .reg_rdata      (reg_rdata),
    .reg_rvalid     (reg_rvalid),
    .offset_corr    (offset_corr),
    .gain_corr      (gain_corr)
  );
  cal1_host u_host (
    .core_clk   (core_clk),
    .reg_rdata  (reg_rdata),
    .reg_rvalid (reg_rvalid),
    .reg_addr   (reg_addr),
    .reg_wr     (reg_wr),
    .reg_rd     (reg_rd),
    .reg_wdata  (reg_wdata)
  );
  // ------
  // compare and verdict
  // ------
  task chk(input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task rdc(input logic [5:0] a, input logic [15:0] exp);
    u_host.rd(a, rv);
    chk({8'h00, rv}, {8'h00, exp});
  endtask
  task print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // hang guard, run needs well under a hundred cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 1000) begin
      error_cnt++;
      print_verdict;
    end
  end
  initial begin
    rst_b = 1'b0;
    checksum_load = 1'b0;
    checksum_value = 16'h0000;
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    #1;
    chk(offset_corr, 24'h000000);
    chk(gain_corr, 24'h800000);
    rdc(6'h11, 16'h8000);
    rdc(6'h3E, 16'h0000);
    rdc(6'h3F, 16'h0000);
    $display("test reset done");
    u_host.wr(6'h0F, 16'hA5C3);
    u_host.wr(6'h10, 16'h5AFF);
    u_host.wr(6'h11, 16'h1234);
    u_host.wr(6'h12, 16'hC37E);
    u_host.wr(6'h3E, 16'hFFFF);
    u_host.wr(6'h3F, 16'h7777);
    rdc(6'h0F, 16'hA5C3);
    rdc(6'h11, 16'h1234);
    rdc(6'h10, 16'h5A00);
    rdc(6'h12, 16'hC300);
    rdc(6'h3E, 16'h0000);
    rdc(6'h3F, 16'h0000);
    chk(offset_corr, 24'hA5C35A);
    chk(gain_corr, 24'h1234C3);
    @(posedge core_clk);
    checksum_load <= 1'b1;
    checksum_value <= 16'hBEEF;
    @(posedge core_clk);
    checksum_load <= 1'b0;
    rdc(6'h3E, 16'hBEEF);
    $display("test access done");
    // mid-run reset must bring the written words back to reset values
    rst_b <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    rdc(6'h0F, 16'h0000);
    rdc(6'h11, 16'h8000);
    rdc(6'h3E, 16'h0000);
    chk(offset_corr, 24'h000000);
    chk(gain_corr, 24'h800000);
    $display("test mid reset done");
    print_verdict;
  end
endmodule
`default_nettype wire
